// ===== src/sbos_ctrl.sv
// burst address sequencing and sleep gating of the synchronous burst sram
`timescale 1ns/10ps
module sbos_ctrl #(
   parameter int SLEEP_RECOVERY_CYC = sbos_pkg::SBOS_SLEEP_RECOVERY_CYC  // recovery length
) (
   input  wire logic       clk_sys_i,             // system clock, 200 mhz
   input  wire logic       reset_n_i,             // synchronous reset, active low
   input  wire logic       sleep_request_i,       // asynchronous sleep request, active high
   input  wire logic       flow_through_select_i, // low flow-through, high pipelined
   input  wire logic       burst_order_select_i,  // low linear, high interleaved
   input  wire logic       burst_step_next_i,     // high continue burst, low load
   input  wire logic       cmd_select_i,          // chip selected on a load cycle
   input  wire logic       cmd_write_i,           // high write, low read
   input  wire logic [1:0] addr_lo_i,             // low two bits of the external address
   output logic [1:0]      burst_addr_o,          // low address bits of the access
   output logic            read_strobe_o,         // read access this cycle
   output logic            write_strobe_o,        // write access this cycle
   output logic            dq_oe_o,               // data output drivers enabled
   output logic            pipelined_o,           // pipelined read timing in force
   output logic            sleep_active_o,        // array asleep
   output logic            sleep_recovering_o     // recovery interval running
);

   localparam int BW = sbos_pkg::SBOS_BEAT_W;

   // whole state of the controller
   typedef struct packed {
      logic [BW-1:0] base;      // loaded start bits
      logic [BW-1:0] beat;      // beat count within the burst
      logic          burst_on;  // a burst is open and may continue
      logic [BW-1:0] addr;      // address of the current access
      logic          rd;        // read access
      logic          wr;        // write access
      logic          oe_pipe;   // read data waiting in the output register
      logic          dq_oe;     // output drivers on
      logic          pipelined; // sampled read timing select
   } sbos_ctl_s;

   sbos_ctl_s q;  // registered state
   sbos_ctl_s d;  // next state

   sbos_sleep_if slp ();  // sleep status from the sequencer

   // synchroniser, entry delay and recovery timing
   sbos_sleep_seq #(
      .SLEEP_RECOVERY_CYC (SLEEP_RECOVERY_CYC)
   ) u_sleep (
      .clk_sys_i       (clk_sys_i),
      .reset_n_i       (reset_n_i),
      .sleep_request_i (sleep_request_i),
      .slp             (slp)
   );

   // burst address for a beat in the selected order
   function automatic logic [BW-1:0] burst_addr(input logic [BW-1:0] base,
                                                input logic [BW-1:0] beat,
                                                input logic          interleave);
      if (interleave) begin
         burst_addr = base ^ beat;                 // R1
      end else begin
         burst_addr = base + beat;                 // R12
      end
   endfunction

   // next state: load, continue, deselect, sleep gating
   always_comb begin
      d         = q;
      d.rd      = 1'h0;
      d.wr      = 1'h0;
      d.oe_pipe = 1'h0;
      d.dq_oe   = 1'h0;
      if (slp.asleep) begin
         // every input but the sleep request is ignored; burst state is kept
         d.rd      = 1'h0;                         // R6
         d.dq_oe   = 1'h0;                         // R5
         d.pipelined = q.pipelined;                // R3
      end else begin
         d.pipelined = flow_through_select_i;      // R11 R14
         if (burst_step_next_i) begin
            // continue cycle: the 2-bit beat wraps back on the fifth access
            if (q.burst_on) begin
               d.beat = q.beat + BW'(1);           // R13
               d.addr = burst_addr(q.base, d.beat, burst_order_select_i); // R1 R12
               d.rd   = !cmd_write_i;
               // writes are refused while the array recovers from sleep
               d.wr   = cmd_write_i && !slp.recovering; // R10
            end
         end else if (cmd_select_i) begin
            // load cycle: external address starts a new burst
            d.base     = addr_lo_i;
            d.beat     = '0;
            d.addr     = addr_lo_i;
            d.burst_on = 1'h1;
            d.rd       = !cmd_write_i;
            d.wr       = cmd_write_i && !slp.recovering; // R10
         end else begin
            d.burst_on = 1'h0;                     // deselect closes the burst
         end
         // flow-through drives with the access, pipelined one cycle later
         d.oe_pipe = d.rd;
         d.dq_oe   = q.pipelined ? q.oe_pipe : d.rd; // R11
      end
   end

   // state register, synchronous reset
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         q <= '{base: sbos_pkg::SBOS_ADDR_RST, beat: '0, burst_on: 1'h0,
                addr: sbos_pkg::SBOS_ADDR_RST, rd: 1'h0, wr: 1'h0, oe_pipe: 1'h0,
                dq_oe: 1'h0, pipelined: sbos_pkg::SBOS_PIPELINED_RST};
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops
   assign burst_addr_o       = q.addr;
   assign read_strobe_o      = q.rd;
   assign write_strobe_o     = q.wr;
   assign dq_oe_o            = q.dq_oe;
   assign pipelined_o        = q.pipelined;
   assign sleep_active_o     = slp.asleep;
   assign sleep_recovering_o = slp.recovering;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_step_awake;
      !slp.asleep && burst_step_next_i && q.burst_on;
   endsequence

   // interleaved continue address is start xor next beat
   property p_interleave;
      (s_step_awake and burst_order_select_i)
         |=> burst_addr_o == ($past(q.base) ^ ($past(q.beat) + 2'h1));
   endproperty
   a_interleave: assert property (p_interleave) else $error("interleaved address wrong"); // R1

   // linear continue address is start plus next beat
   property p_linear;
      (s_step_awake and !burst_order_select_i)
         |=> burst_addr_o == ($past(q.base) + ($past(q.beat) + 2'h1));
   endproperty
   a_linear: assert property (p_linear) else $error("linear address wrong"); // R12

   // load takes the external address at beat zero
   property p_load;
      (!slp.asleep && !burst_step_next_i && cmd_select_i)
         |=> burst_addr_o == $past(addr_lo_i) && q.beat == 2'h0 && q.burst_on;
   endproperty
   a_load: assert property (p_load) else $error("burst load wrong"); // R13

   // no access and no drive while asleep
   property p_sleep_quiet;
      slp.asleep |=> !read_strobe_o && !write_strobe_o && !dq_oe_o;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity while asleep"); // R5

   // burst state frozen through sleep
   property p_sleep_hold;
      slp.asleep |=> $stable(q.base) && $stable(q.beat) && $stable(q.burst_on);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("state lost in sleep"); // R3

   // flow-through drives in the read cycle itself
   property p_flow_through;
      (read_strobe_o && !$past(pipelined_o)) |-> dq_oe_o;
   endproperty
   a_flow_through: assert property (p_flow_through) else $error("flow-through oe missing"); // R11

   // pipelined drives one cycle after the read
   property p_pipelined;
      (read_strobe_o && pipelined_o && !slp.asleep) |=> dq_oe_o;
   endproperty
   a_pipelined: assert property (p_pipelined) else $error("pipelined oe missing"); // R14

endmodule

// ===== src/sbos_pkg.sv
// constants, types and mode encodings for the burst order and sleep controller
// Summary of operation
// R1 - interleaved order XORs start bits with beat
// R2 - sleep entered two cycles after request rises
// R3 - sleep keeps burst counter and control state
// R4 - normal operation resumes after recovery time elapses
// R5 - asleep: ignore inputs, data outputs high impedance
// R6 - asleep: deselected, no read or write access
// R7 - sleep request is asynchronous, active high
// R8 - host holds sleep request low normally
// R9 - host finishes pending accesses before sleeping
// R10 - host issues no writes during recovery
// R11 - static flow-through or pipelined read timing select
// R12 - order select low linear, high interleaved
// R13 - step input high advances internal burst counter
// R14 - flow-through select high means pipelined default
// R15 - recovery counted in cycles from synchronised fall
// R16 - sleep request synchronised before entry delay counting
package sbos_pkg;

   localparam int          SBOS_BEAT_W            = 2;    // low address bits walked by a burst
   localparam int          SBOS_SYNC_STAGES       = 2;    // flops in the sleep request synchroniser
   localparam int          SBOS_SLEEP_ENTRY_CYC   = 2;    // cycles from synced request to sleep
   localparam int          SBOS_CLK_PERIOD_NS     = 5;    // 200 mhz system clock
   localparam int          SBOS_SLEEP_RECOVERY_NS = 100;  // sleep_recovery_time, plain default
   // least time, so round up to whole cycles
   localparam int          SBOS_SLEEP_RECOVERY_CYC =
      (SBOS_SLEEP_RECOVERY_NS + SBOS_CLK_PERIOD_NS - 1) / SBOS_CLK_PERIOD_NS;

   localparam logic [1:0]  SBOS_ADDR_RST          = 2'h0; // burst address after reset
   localparam logic        SBOS_PIPELINED_RST     = 1'h1; // pipelined mode after reset

   // power state of the array
   typedef enum logic [1:0] {
      SBOS_AWAKE,
      SBOS_ENTER,
      SBOS_ASLEEP,
      SBOS_RECOVER
   } sbos_sleep_e;

endpackage

// ===== src/sbos_sleep_if.sv
// sleep status carried from the sleep sequencer to the burst controller
`timescale 1ns/10ps
interface sbos_sleep_if;
   logic asleep;      // array powered down, all inputs but the sleep request ignored
   logic recovering;  // recovery interval after leaving sleep
   logic entering;    // request seen, entry delay running

   modport seq (output asleep, output recovering, output entering);
   modport ctl (input asleep, input recovering, input entering);
endinterface

// ===== src/sbos_sleep_seq.sv
// sleep request synchroniser, entry delay and recovery timer
`timescale 1ns/10ps
module sbos_sleep_seq #(
   parameter int SLEEP_RECOVERY_CYC = sbos_pkg::SBOS_SLEEP_RECOVERY_CYC  // recovery length
) (
   input  wire logic     clk_sys_i,        // system clock
   input  wire logic     reset_n_i,        // synchronous reset, active low
   input  wire logic     sleep_request_i,  // asynchronous sleep request pin
   sbos_sleep_if.seq     slp               // sleep status to the controller
);

   localparam int CW = $clog2(SLEEP_RECOVERY_CYC + sbos_pkg::SBOS_SLEEP_ENTRY_CYC + 1) + 1;

   // whole state of the sequencer
   typedef struct packed {
      logic                 sync1;  // first synchroniser stage, read only by sync2
      logic                 sync2;  // request in the clock domain
      sbos_pkg::sbos_sleep_e st;    // power state
      logic [CW-1:0]        cnt;    // entry or recovery cycle count
      logic                 asleep; // registered copy of the asleep state
      logic                 recov;  // registered copy of the recovery state
      logic                 enter;  // registered copy of the entry state
   } sbos_slp_s;

   sbos_slp_s q;  // registered state
   sbos_slp_s d;  // next state

   // next state: entry delay, sleep hold, recovery timer
   always_comb begin
      d       = q;
      d.sync1 = sleep_request_i;                 // R7
      d.sync2 = q.sync1;                         // R16
      case (q.st)
         sbos_pkg::SBOS_AWAKE: begin
            if (q.sync2) begin
               d.st  = sbos_pkg::SBOS_ENTER;     // R16
               d.cnt = CW'(1);
            end
         end
         sbos_pkg::SBOS_ENTER: begin
            // a request that drops before the delay ends is dropped too
            if (!q.sync2) begin
               d.st  = sbos_pkg::SBOS_AWAKE;
               d.cnt = '0;
            end else if (q.cnt >= CW'(sbos_pkg::SBOS_SLEEP_ENTRY_CYC - 1)) begin
               d.st  = sbos_pkg::SBOS_ASLEEP;    // R2
               d.cnt = '0;
            end else begin
               d.cnt = q.cnt + CW'(1);
            end
         end
         sbos_pkg::SBOS_ASLEEP: begin
            // stays asleep as long as the request stays high
            if (!q.sync2) begin
               d.st  = sbos_pkg::SBOS_RECOVER;   // R15
               d.cnt = CW'(1);
            end
         end
         sbos_pkg::SBOS_RECOVER: begin
            if (q.sync2) begin
               d.st  = sbos_pkg::SBOS_ENTER;     // re-request restarts entry
               d.cnt = CW'(1);
            end else if (q.cnt >= CW'(SLEEP_RECOVERY_CYC)) begin
               d.st  = sbos_pkg::SBOS_AWAKE;     // R4
               d.cnt = '0;
            end else begin
               d.cnt = q.cnt + CW'(1);           // R15
            end
         end
         default: begin
            d.st  = sbos_pkg::SBOS_AWAKE;
            d.cnt = '0;
         end
      endcase
      // status decoded ahead of the flop so the outputs carry no logic
      d.asleep = (d.st == sbos_pkg::SBOS_ASLEEP);
      d.recov  = (d.st == sbos_pkg::SBOS_RECOVER);
      d.enter  = (d.st == sbos_pkg::SBOS_ENTER);
   end

   // state register, synchronous reset to awake
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         q <= '{sync1: 1'h0, sync2: 1'h0, st: sbos_pkg::SBOS_AWAKE, cnt: '0,
                asleep: 1'h0, recov: 1'h0, enter: 1'h0};
      end else begin
         q <= d;
      end
   end

   // status straight from the state flops
   assign slp.asleep     = q.asleep;
   assign slp.recovering = q.recov;
   assign slp.entering   = q.enter;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   // request reaches the domain after the synchroniser stages
   property p_sync_delay;
      sleep_request_i |-> ##2 q.sync2;
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sleep request not synchronised in 2"); // R16

   sequence s_req_held;
      ($rose(q.sync2) && q.st == sbos_pkg::SBOS_AWAKE) ##1 q.sync2;
   endsequence

   // asleep exactly two cycles after the synced rise
   property p_entry_time;
      s_req_held |=> (q.st == sbos_pkg::SBOS_ASLEEP);
   endproperty
   a_entry_time: assert property (p_entry_time) else $error("sleep not entered after 2 cycles"); // R2

   property p_entry_not_early;
      ($rose(q.sync2) && q.st == sbos_pkg::SBOS_AWAKE) |-> !slp.asleep ##1 !slp.asleep;
   endproperty
   a_entry_not_early: assert property (p_entry_not_early) else $error("sleep entered too early"); // R2

   // recovery starts on the synced fall
   property p_recover_start;
      (q.st == sbos_pkg::SBOS_ASLEEP && !q.sync2) |=> slp.recovering && q.cnt == CW'(1);
   endproperty
   a_recover_start: assert property (p_recover_start) else $error("recovery did not start"); // R15

   property p_recover_hold;
      (slp.recovering && !q.sync2 && q.cnt < CW'(SLEEP_RECOVERY_CYC)) |=> slp.recovering;
   endproperty
   a_recover_hold: assert property (p_recover_hold) else $error("recovery ended early"); // R4

   property p_recover_end;
      (slp.recovering && !q.sync2 && q.cnt >= CW'(SLEEP_RECOVERY_CYC))
         |=> q.st == sbos_pkg::SBOS_AWAKE;
   endproperty
   a_recover_end: assert property (p_recover_end) else $error("recovery did not end on time"); // R4

endmodule

// ===== bench/sbos_host_model.sv
// host memory controller model driving commands and the sleep request
`timescale 1ns/10ps
module sbos_host_model (
   input  wire logic       clk_sys_i,       // system clock
   output logic            sleep_request_o, // sleep request to the device
   output logic            step_o,          // high continue, low load
   output logic            select_o,        // chip select on a load
   output logic            write_o,         // high write, low read
   output logic [1:0]      addr_o           // low address bits
);
   // idle host: request low, deselected
   initial begin
      sleep_request_o = 1'h0;
      step_o          = 1'h0;
      select_o        = 1'h0;
      write_o         = 1'h0;
      addr_o          = 2'h0;
   end

   // one command a cycle, launched at the falling edge so it is settled at the rising one
   task automatic cmd(input logic st, input logic sel, input logic wr, input logic [1:0] a);
      @(negedge clk_sys_i);
      step_o   = st;
      select_o = sel;
      write_o  = wr;
      addr_o   = a;
   endtask

   // callers may sleep in mid-burst and drive writes during recovery; this task only sets the request
   task automatic set_sleep(input logic v);
      @(negedge clk_sys_i);
      sleep_request_o = v;
   endtask
endmodule

// ===== bench/sbos_burst_order_sleep_ctrl_test.sv
// self-checking bench for the burst order and sleep controller
`timescale 1ns/10ps
module sbos_burst_order_sleep_ctrl_test;
   localparam int RCY = 4;                  // short recovery keeps the run brief
   logic       clk_sys_i             = 1'h0; // system clock
   logic       reset_n_i             = 1'h0; // reset, active low
   logic       flow_through_select_i = 1'h1; // pipelined default
   logic       burst_order_select_i  = 1'h0; // linear default
   logic       sleep_request;                // from the host model
   logic       step;                         // from the host model
   logic       sel;                          // from the host model
   logic       wr;                           // from the host model
   logic [1:0] addr;                         // from the host model
   logic [1:0] burst_addr_o;                 // device outputs
   logic       read_strobe_o;
   logic       write_strobe_o;
   logic       dq_oe_o;
   logic       pipelined_o;
   logic       sleep_active_o;
   logic       sleep_recovering_o;
   int         err_total = 0;                // mismatches
   int         compares  = 0;                // comparisons made

   // 200 mhz clock
   always #2.5 clk_sys_i = ~clk_sys_i;

   sbos_host_model host_u (.clk_sys_i(clk_sys_i), .sleep_request_o(sleep_request),
      .step_o(step), .select_o(sel), .write_o(wr), .addr_o(addr));

   sbos_ctrl #(.SLEEP_RECOVERY_CYC(RCY)) dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .sleep_request_i(sleep_request), .flow_through_select_i(flow_through_select_i),
      .burst_order_select_i(burst_order_select_i), .burst_step_next_i(step),
      .cmd_select_i(sel), .cmd_write_i(wr), .addr_lo_i(addr), .burst_addr_o(burst_addr_o),
      .read_strobe_o(read_strobe_o), .write_strobe_o(write_strobe_o), .dq_oe_o(dq_oe_o),
      .pipelined_o(pipelined_o), .sleep_active_o(sleep_active_o),
      .sleep_recovering_o(sleep_recovering_o));

   // one comparison, counted
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // verdict and end of run
   task automatic end_sim();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // every read seen in a base-1 interleaved burst must carry the next beat
   task automatic track(inout logic [1:0] beat);
      if (read_strobe_o === 1'h1) begin
         chk("kept_addr", 8'(2'h1 ^ beat), 8'(burst_addr_o));
         beat++;
      end
   endtask

   // read then write back to back, output enable timing per mode
   task automatic t_outen(input logic ft);
      flow_through_select_i = ft;
      host_u.cmd(1'h0, 1'h0, 1'h0, 2'h0);
      host_u.cmd(1'h0, 1'h1, 1'h0, 2'h2);
      host_u.cmd(1'h0, 1'h1, 1'h1, 2'h1);
      chk("pipelined", 8'(ft), 8'(pipelined_o));
      chk("rd_oe", 8'({1'h1, ~ft, 2'h2}), 8'({read_strobe_o, dq_oe_o, burst_addr_o}));
      host_u.cmd(1'h0, 1'h0, 1'h0, 2'h0);
      chk("wr_oe", 8'({1'h1, ft, 2'h1}), 8'({write_strobe_o, dq_oe_o, burst_addr_o}));
   endtask

   // every start address, load plus four steps, fifth clock back at the start
   task automatic t_burst(input logic ord);
      logic [1:0] b;
      logic [1:0] e;
      burst_order_select_i = ord;
      for (int base = 0; base < 4; base++) begin
         b = 2'(base);
         host_u.cmd(1'h0, 1'h1, 1'h0, b);
         for (int k = 1; k <= 5; k++) begin
            host_u.cmd(1'h1, 1'h0, 1'h0, b);
            e = ord ? (b ^ 2'(k - 1)) : (b + 2'(k - 1));
            chk("burst", 8'({read_strobe_o, e}), 8'({read_strobe_o, burst_addr_o}));
            chk("rd_strobe", 8'h1, 8'(read_strobe_o));
         end
      end
      host_u.cmd(1'h0, 1'h0, 1'h0, 2'h0);
   endtask

   // one-cycle request drops before entry completes, no sleep
   task automatic t_abort();
      host_u.set_sleep(1'h1);
      host_u.set_sleep(1'h0);
      repeat (12) begin
         @(negedge clk_sys_i);
         chk("abort_sleep", 8'h0, 8'(sleep_active_o));
      end
   endtask

   // sleep in mid-burst, commands ignored, burst resumes in recovery with writes refused
   task automatic t_sleep();
      logic [1:0] beat;
      int         n;
      int         r;
      burst_order_select_i = 1'h1;
      beat = 2'h0;
      host_u.cmd(1'h0, 1'h1, 1'h0, 2'h1);
      host_u.cmd(1'h1, 1'h0, 1'h0, 2'h1);
      track(beat);
      host_u.set_sleep(1'h1);
      track(beat);
      n = 0;
      while (sleep_active_o !== 1'h1 && n < 12) begin
         @(negedge clk_sys_i);
         n++;
         track(beat);
      end
      chk("entry", 8'(sbos_pkg::SBOS_SYNC_STAGES + sbos_pkg::SBOS_SLEEP_ENTRY_CYC), 8'(n));
      // loads, writes and steps while asleep
      host_u.cmd(1'h0, 1'h1, 1'h1, 2'h2);
      host_u.cmd(1'h1, 1'h0, 1'h1, 2'h0);
      host_u.cmd(1'h0, 1'h1, 1'h0, 2'h3);
      host_u.cmd(1'h1, 1'h0, 1'h0, 2'h1);
      chk("asleep", 8'h1, 8'({read_strobe_o | write_strobe_o, dq_oe_o, sleep_active_o}));
      host_u.set_sleep(1'h0);
      chk("asleep2", 8'h1, 8'({read_strobe_o | write_strobe_o, dq_oe_o, sleep_active_o}));
      n = 0;
      while (sleep_recovering_o !== 1'h1 && n < 12) begin
         @(negedge clk_sys_i);
         n++;
         track(beat);
      end
      chk("exit", 8'(sbos_pkg::SBOS_SYNC_STAGES + 1), 8'(n));
      r = 1;
      host_u.cmd(1'h0, 1'h1, 1'h1, 2'h2);
      chk("resume_rd", 8'h1, 8'(read_strobe_o));
      track(beat);
      if (sleep_recovering_o === 1'h1) r++;
      while (sleep_recovering_o === 1'h1 && r < 12) begin
         host_u.cmd(1'h0, 1'h0, 1'h0, 2'h0);
         chk("rec_write", 8'h0, 8'(write_strobe_o));
         if (sleep_recovering_o === 1'h1) r++;
      end
      chk("rec_len", 8'(RCY), 8'(r));
      chk("awake", 8'h0, 8'({sleep_active_o, sleep_recovering_o}));
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk("reset", 8'h04, 8'({burst_addr_o, read_strobe_o, write_strobe_o, dq_oe_o,
         pipelined_o, sleep_active_o, sleep_recovering_o}));
      reset_n_i = 1'h1;
      t_outen(1'h0);
      t_outen(1'h1);
      t_burst(1'h0);
      t_burst(1'h1);
      t_abort();
      t_sleep();
      end_sim();
   end
endmodule
